/* File: shared/tcr_regs.svh */
// register offsets, field positions and reset values of the capture timer
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH
// byte addresses, one aligned 32-bit word each, data in bits 7:0
`define TCR_OFS_CNT_HI 8'h00
`define TCR_OFS_CNT_LO 8'h04
`define TCR_OFS_RLD_HI 8'h08
`define TCR_OFS_RLD_LO 8'h0c
`define TCR_OFS_CTL 8'h10
`define TCR_OFS_CAP_HI 8'h14
`define TCR_OFS_CAP_LO 8'h18
`define TCR_OFS_STS 8'h1c
// timer_control_zero fields
`define TCR_CTL_EN 7
`define TCR_CTL_SEL_HI 6
`define TCR_CTL_SEL_LO 5
`define TCR_CTL_POL 4
`define TCR_CTL_PS_HI 2
`define TCR_CTL_PS_LO 0
// interrupt_event_select encodings
`define TCR_SEL_BOTH 2'h0
`define TCR_SEL_CAPT 2'h1
`define TCR_SEL_RELOAD 2'h2
// status fields
`define TCR_STS_CAP 0
`define TCR_STS_REL 1
`define TCR_STS_RUN 2
// reset values, then the count loaded on reload
`define TCR_RST_CTL 8'h00
`define TCR_RST_CNT 16'h0001
`define TCR_RST_RLD 16'hffff
`define TCR_RELOAD_START 16'h0001
// axi responses
`define TCR_RESP_OKAY 2'h0
`define TCR_RESP_SLVERR 2'h2
`endif

/* File: shared/tcr_pkg.sv */
// types shared by the capture timer modules
package tcr_pkg;
  typedef enum logic [1:0] {
    TCR_IDLE,
    TCR_ARMED,
    TCR_COUNTING
  } tcr_phase_t;

  typedef struct packed {
    tcr_phase_t st;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] capt;
    logic [7:0] ctl;
    logic [7:0] hold;
    logic [1:0] sts;
    logic tout;
    logic irq;
    logic in_prev;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcr_main_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } tcr_pre_t;
endpackage

/* File: shared/tcr_tick_if.sv */
// prescaler hookup between the timer core and its divider
`timescale 1ns/1ns
`default_nettype none
interface tcr_tick_if;
  logic run;
  logic [2:0] ps;
  logic tick;
  modport ctrl (output run, output ps, input tick);
  modport pre (input run, input ps, output tick);
endinterface
`default_nettype wire

/* File: verilog/tcr_prescaler.sv */
// prescale divider: one tick every 2^ps clocks while running
`timescale 1ns/1ns
`default_nettype none
module tcr_prescaler #(
  parameter int PS_W = 3
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // divider link
  tcr_tick_if.pre bus
);
  tcr_pkg::tcr_pre_t q;
  tcr_pkg::tcr_pre_t d;
  logic [6:0] lim;

  generate
    if (PS_W < 1 || PS_W > 3) begin : g_chk
      $error("prescale width must be 1 to 3");
    end
  endgenerate

  // divider restarts whenever counting stops so each start is aligned
  always_comb begin
    lim = 7'((8'h01 << bus.ps) - 8'h01);
    d = q;
    d.tick = bus.run && (q.cnt == lim);
    if (!bus.run || q.cnt == lim) begin
      d.cnt = 7'h00;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.tick = q.tick;
endmodule
`default_nettype wire

/* File: verilog/tcr_timer.sv */
// capture/compare timer with coherent count reads over axi4-lite
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "tcr_regs.svh"
module tcr_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // timer pins and event
  input wire logic i_timer_in,
  output logic o_timer_out,
  output logic o_timer_irq
);
  tcr_pkg::tcr_main_t q;
  tcr_pkg::tcr_main_t d;
  tcr_tick_if tick_bus ();
  logic en;
  logic edge_hit;
  logic cap_ev;
  logic rel_ev;
  logic wr_do;
  logic rd_do;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [1:0] sel;
  logic [1:0] clr;

  generate
    if (CNT_W != 16) begin : g_chk
      $error("count width must be 16, reads are split in two bytes");
    end
  endgenerate

  // ****************************************************************
  // prescaler
  // ****************************************************************
  assign tick_bus.run = (q.st == tcr_pkg::TCR_COUNTING);
  assign tick_bus.ps = q.ctl[`TCR_CTL_PS_HI:`TCR_CTL_PS_LO];

  tcr_prescaler #(.PS_W(3)) u_pre (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(tick_bus.pre)
  );

  // ****************************************************************
  // timer core and register slave
  // ****************************************************************
  // qualifying edge: pol clear means rising, set means falling
  always_comb begin
    en = q.ctl[`TCR_CTL_EN];
    sel = q.ctl[`TCR_CTL_SEL_HI:`TCR_CTL_SEL_LO];
    edge_hit = q.ctl[`TCR_CTL_POL] ? (q.in_prev & ~i_timer_in)
                                   : (~q.in_prev & i_timer_in);
    wa = {q.awaddr[7:2], 2'b00};
    ra = {i_araddr[7:2], 2'b00};
    wr_do = q.aw_have && q.w_have && !q.bvalid;
    rd_do = i_arvalid && q.arready;
    clr = 2'b00;
    if (wr_do && wa == `TCR_OFS_STS && q.wstrb0) begin
      clr = q.wdata[1:0];
    end
    cap_ev = 1'b0;
    rel_ev = 1'b0;
    d = q;
    d.irq = 1'b0;
    d.in_prev = i_timer_in;
    case (q.st)
      tcr_pkg::TCR_IDLE: begin
        if (en) begin
          d.st = tcr_pkg::TCR_ARMED;
        end
      end
      tcr_pkg::TCR_ARMED: begin
        if (!en) begin
          d.st = tcr_pkg::TCR_IDLE;
        end else if (edge_hit) begin
          d.st = tcr_pkg::TCR_COUNTING;
        end
      end
      tcr_pkg::TCR_COUNTING: begin
        if (!en) begin
          d.st = tcr_pkg::TCR_IDLE;
        end else begin
          if (tick_bus.tick) begin
            if (q.cnt == q.rld) begin
              d.cnt = `TCR_RELOAD_START;
              d.tout = ~q.tout;
              rel_ev = 1'b1;
            end else begin
              d.cnt = q.cnt + 16'h0001;
            end
          end
          if (edge_hit) begin
            d.capt = q.cnt;
            cap_ev = 1'b1;
          end
        end
      end
      default: begin
        d.st = tcr_pkg::TCR_IDLE;
      end
    endcase
    // event filter onto the interrupt pulse
    d.irq = (cap_ev && sel != `TCR_SEL_RELOAD) ||
            (rel_ev && sel != `TCR_SEL_CAPT);
    // sticky flags: a new event wins over a same-cycle clear
    d.sts = (q.sts & ~clr) | {rel_ev, cap_ev};
    // write channels are taken independently, in either order
    if (i_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = i_awaddr;
    end
    if (i_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = i_wdata[7:0];
      d.wstrb0 = i_wstrb[0];
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_do) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `TCR_RESP_OKAY;
      case (wa)
        `TCR_OFS_CNT_HI: begin
          // start value only loads while stopped, so counting is never torn
          if (q.wstrb0 && !en) begin
            d.cnt[15:8] = q.wdata;
          end
        end
        `TCR_OFS_CNT_LO: begin
          if (q.wstrb0 && !en) begin
            d.cnt[7:0] = q.wdata;
          end
        end
        `TCR_OFS_RLD_HI: begin
          if (q.wstrb0) begin
            d.rld[15:8] = q.wdata;
          end
        end
        `TCR_OFS_RLD_LO: begin
          if (q.wstrb0) begin
            d.rld[7:0] = q.wdata;
          end
        end
        `TCR_OFS_CTL: begin
          if (q.wstrb0) begin
            d.ctl = q.wdata;
          end
        end
        `TCR_OFS_STS, `TCR_OFS_CAP_HI, `TCR_OFS_CAP_LO: begin
          d.bresp = `TCR_RESP_OKAY;
        end
        default: begin
          d.bresp = `TCR_RESP_SLVERR;
        end
      endcase
    end
    // reads: side effects only on the holding byte, never on counting
    if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_do) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0000_0000;
      d.rresp = `TCR_RESP_OKAY;
      case (ra)
        `TCR_OFS_CNT_HI: begin
          d.rdata[7:0] = q.cnt[15:8];
          if (en) begin
            d.hold = q.cnt[7:0];
          end
        end
        `TCR_OFS_CNT_LO: begin
          d.rdata[7:0] = en ? q.hold : q.cnt[7:0];
        end
        `TCR_OFS_RLD_HI: d.rdata[7:0] = q.rld[15:8];
        `TCR_OFS_RLD_LO: d.rdata[7:0] = q.rld[7:0];
        `TCR_OFS_CTL: d.rdata[7:0] = q.ctl;
        `TCR_OFS_CAP_HI: d.rdata[7:0] = q.capt[15:8];
        `TCR_OFS_CAP_LO: d.rdata[7:0] = q.capt[7:0];
        `TCR_OFS_STS: begin
          d.rdata[1:0] = q.sts;
          d.rdata[`TCR_STS_RUN] = (q.st == tcr_pkg::TCR_COUNTING);
        end
        default: d.rresp = `TCR_RESP_SLVERR;
      endcase
    end
    // one write and one read under way at a time
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= tcr_pkg::TCR_IDLE;
      q.cnt <= `TCR_RST_CNT;
      q.rld <= `TCR_RST_RLD;
      q.ctl <= `TCR_RST_CTL;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign o_awready = q.awready;
  assign o_wready = q.wready;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_arready = q.arready;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign o_timer_out = q.tout;
  assign o_timer_irq = q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_armed_holds_cnt: assert property (
    q.st == tcr_pkg::TCR_ARMED && !wr_do |=> $stable(q.cnt))
    else $error("count moved before first input edge");
  a_first_edge_quiet: assert property (
    q.st == tcr_pkg::TCR_ARMED && en && edge_hit
      |=> q.st == tcr_pkg::TCR_COUNTING && !q.irq)
    else $error("first edge misbehaved");
  a_count_step: assert property (
    q.st == tcr_pkg::TCR_COUNTING && en && tick_bus.tick && q.cnt != q.rld
      |=> q.cnt == 16'($past(q.cnt) + 16'h0001))
    else $error("count did not step by one");
  a_reload_toggle: assert property (
    q.st == tcr_pkg::TCR_COUNTING && en && tick_bus.tick && q.cnt == q.rld
      |=> q.tout != $past(q.tout) && q.cnt == `TCR_RELOAD_START)
    else $error("reload did not toggle output");
  a_read_no_disturb: assert property (
    rd_do && q.st == tcr_pkg::TCR_COUNTING && en && !tick_bus.tick
      |=> $stable(q.cnt) && q.st == tcr_pkg::TCR_COUNTING)
    else $error("read disturbed the count");
  a_hold_on_hi: assert property (
    rd_do && ra == `TCR_OFS_CNT_HI && en |=> q.hold == $past(q.cnt[7:0]))
    else $error("holding byte not loaded");
  a_lo_from_hold: assert property (
    rd_do && ra == `TCR_OFS_CNT_LO && en |=> q.rdata[7:0] == $past(q.hold))
    else $error("low byte not from holding");
  a_lo_live: assert property (
    rd_do && ra == `TCR_OFS_CNT_LO && !en
      |=> q.rdata[7:0] == $past(q.cnt[7:0]))
    else $error("low byte not live while stopped");
  a_capture_latch: assert property (
    q.st == tcr_pkg::TCR_COUNTING && en && edge_hit
      |=> q.capt == $past(q.cnt) && q.sts[`TCR_STS_CAP]
          && (q.irq == ($past(sel) != `TCR_SEL_RELOAD
                        || ($past(rel_ev) && $past(sel) != `TCR_SEL_CAPT))))
    else $error("capture not latched or filtered");
  a_reload_filter: assert property (
    q.st == tcr_pkg::TCR_COUNTING && en && tick_bus.tick && q.cnt == q.rld
      && !edge_hit |=> q.irq == ($past(sel) != `TCR_SEL_CAPT))
    else $error("reload interrupt filter wrong");
endmodule
`default_nettype wire

/* File: bench/tcr_pin_src.sv */
// partner model: the outside signal that drives the timer input pin
`timescale 1ns/1ns
`default_nettype none
module tcr_pin_src (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request and idle level
  input wire logic i_go,
  input wire logic i_pol,
  // timer input pin
  output logic o_pin
);
  logic [1:0] act_q;
  // a request gives one clean active pulse of three clocks
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_q <= 2'h0;
    end else if (i_go) begin
      act_q <= 2'h3;
    end else if (act_q != 2'h0) begin
      act_q <= act_q - 2'h1;
    end
  end
  // pin rests at its idle level so no stray edge reaches the timer
  assign o_pin = i_pol ^ (act_q != 2'h0);
endmodule
`default_nettype wire

/* File: bench/timer_capture_count_read_tb.sv */
// self-checking bench for the capture timer over axi4-lite
`timescale 1ns/1ns
`default_nettype none
`include "tcr_regs.svh"
module timer_capture_count_read_tb;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, go, pol;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, h, l, h2, l2, c, v;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pin, tout, irq, tout_q;
  int err_count, n_compared, n_irq, n_tog, cyc, c1, c2, i0, t0;

  tcr_timer DUT (.i_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'h1), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_timer_in(pin),
    .o_timer_out(tout), .o_timer_irq(irq));
  tcr_pin_src SRC (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_pol(pol),
    .o_pin(pin));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // event monitor: irq pulses, output toggles, cycle count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (tout !== tout_q) n_tog <= n_tog + 1;
    tout_q <= tout;
  end

  // ****************************************
  // bus tasks and comparison
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready/response sampled at the edge; a lost answer leaves code 3
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    logic [1:0] rs;
    rs = 2'h3;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    repeat (50) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        break;
      end
    end
    chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
    output logic [31:0] d);
    logic [1:0] rs;
    rs = 2'h3;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    repeat (50) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        rs = rresp;
        break;
      end
    end
    chk({30'h0, rs}, {30'h0, er});
  endtask

  // high byte first so the pair stays coherent while running
  task automatic rc(input logic [7:0] a, output logic [31:0] d);
    rd(a, `TCR_RESP_OKAY, h);
    rd(a + 8'h04, `TCR_RESP_OKAY, l);
    d = {16'h0, h[7:0], l[7:0]};
  endtask

  task automatic pulse;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #40000;
    err_count++;
    test_done;
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, arvalid, go, pol} = 5'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0;
    {err_count, n_compared, n_irq, n_tog, cyc} = '0;
    tout_q = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rc(`TCR_OFS_CNT_HI, v);
    chk(v, 32'h0001);
    rc(`TCR_OFS_RLD_HI, v);
    chk(v, 32'hffff);
    rd(`TCR_OFS_CTL, `TCR_RESP_OKAY, v);
    chk(v, 32'h0);
    rd(8'h20, `TCR_RESP_SLVERR, v);
    wr(8'h20, 8'h5a, `TCR_RESP_SLVERR);
    $display("test reset done");
    // disabled: low byte read is the live counter, no holding
    wr(`TCR_OFS_CNT_HI, 8'h12, `TCR_RESP_OKAY);
    wr(`TCR_OFS_CNT_LO, 8'h34, `TCR_RESP_OKAY);
    rd(`TCR_OFS_CNT_HI, `TCR_RESP_OKAY, v);
    wr(`TCR_OFS_CNT_LO, 8'h35, `TCR_RESP_OKAY);
    rd(`TCR_OFS_CNT_LO, `TCR_RESP_OKAY, v);
    chk(v, 32'h35);
    $display("test disabled read done");
    // enabled but waiting for the first input edge
    wr(`TCR_OFS_CTL, 8'h80, `TCR_RESP_OKAY);
    repeat (10) @(posedge clk);
    rc(`TCR_OFS_CNT_HI, v);
    chk(v, 32'h1235);
    i0 = n_irq;
    pulse;
    repeat (10) @(posedge clk);
    chk(32'(n_irq - i0), 32'h0);
    // two coherent reads, low byte fetched 20 clocks late the first time
    c1 = cyc;
    rd(`TCR_OFS_CNT_HI, `TCR_RESP_OKAY, h);
    repeat (20) @(posedge clk);
    rd(`TCR_OFS_CNT_LO, `TCR_RESP_OKAY, l);
    c2 = cyc;
    rd(`TCR_OFS_CNT_HI, `TCR_RESP_OKAY, h2);
    rd(`TCR_OFS_CNT_LO, `TCR_RESP_OKAY, l2);
    h2 = {16'h0, h2[7:0], l2[7:0]};
    chk(h2 - {16'h0, h[7:0], l[7:0]}, 32'(c2 - c1));
    $display("test coherent read done");
    // capture with both events enabled
    i0 = n_irq;
    pulse;
    repeat (5) @(posedge clk);
    chk(32'(n_irq - i0), 32'h1);
    rc(`TCR_OFS_CAP_HI, c);
    rc(`TCR_OFS_CNT_HI, v);
    chk({31'h0, c > h2 && c < v}, 32'h1);
    rd(`TCR_OFS_STS, `TCR_RESP_OKAY, v);
    chk({31'h0, v[`TCR_STS_CAP]}, 32'h1);
    $display("test capture done");
    // reload every 16 clocks, reload events only
    wr(`TCR_OFS_CTL, 8'h00, `TCR_RESP_OKAY);
    wr(`TCR_OFS_CNT_HI, 8'h00, `TCR_RESP_OKAY);
    wr(`TCR_OFS_CNT_LO, 8'h01, `TCR_RESP_OKAY);
    wr(`TCR_OFS_RLD_HI, 8'h00, `TCR_RESP_OKAY);
    wr(`TCR_OFS_RLD_LO, 8'h10, `TCR_RESP_OKAY);
    wr(`TCR_OFS_CTL, 8'hc0, `TCR_RESP_OKAY);
    pulse;
    repeat (4) @(posedge clk);
    t0 = n_tog;
    i0 = n_irq;
    repeat (48) @(posedge clk);
    chk(32'(n_tog - t0), 32'h3);
    chk(32'(n_irq - i0), 32'h3);
    // a capture in this window must stay silent
    i0 = n_irq;
    pulse;
    repeat (46) @(posedge clk);
    chk(32'(n_irq - i0), 32'h3);
    $display("test reload done");
    // capture events only: reloads silent, capture heard
    wr(`TCR_OFS_CTL, 8'h00, `TCR_RESP_OKAY);
    wr(`TCR_OFS_CTL, 8'ha0, `TCR_RESP_OKAY);
    i0 = n_irq;
    pulse;
    repeat (48) @(posedge clk);
    chk(32'(n_irq - i0), 32'h0);
    pulse;
    repeat (5) @(posedge clk);
    chk(32'(n_irq - i0), 32'h1);
    $display("test capture select done");
    // prescale by 4, falling edges, both events; reload moved out of reach
    wr(`TCR_OFS_CTL, 8'h00, `TCR_RESP_OKAY);
    wr(`TCR_OFS_RLD_HI, 8'hff, `TCR_RESP_OKAY);
    pol <= 1'b1;
    wr(`TCR_OFS_CTL, 8'hf2, `TCR_RESP_OKAY);
    pulse;
    repeat (4) @(posedge clk);
    // snapshots 64 clocks apart: exactly 16 prescaled steps, any phase
    c1 = cyc;
    rc(`TCR_OFS_CNT_HI, c);
    while (cyc - c1 < 64) @(posedge clk);
    rc(`TCR_OFS_CNT_HI, v);
    chk(v - c, 32'h10);
    i0 = n_irq;
    pulse;
    repeat (5) @(posedge clk);
    chk(32'(n_irq - i0), 32'h1);
    // write one clears both sticky flags, running bit stays
    wr(`TCR_OFS_STS, 8'h03, `TCR_RESP_OKAY);
    rd(`TCR_OFS_STS, `TCR_RESP_OKAY, v);
    chk(v, 32'h4);
    $display("test prescale done");
    test_done;
  end
endmodule
`default_nettype wire
